// file: core/rpc_regs.svh
// Register offsets, fields and codes of the reservation/prefetch block
`ifndef RPC_REGS_SVH
`define RPC_REGS_SVH
// Register byte offsets
`define RPC_CMD_OFS     8'h00
`define RPC_ACTION_OFS  8'h04
`define RPC_RKEYL_OFS   8'h08
`define RPC_RKEYH_OFS   8'h0c
`define RPC_AKEYL_OFS   8'h10
`define RPC_AKEYH_OFS   8'h14
`define RPC_CDB0_OFS    8'h18
`define RPC_CDB1_OFS    8'h1c
`define RPC_CDB2_OFS    8'h20
`define RPC_CDB3_OFS    8'h24
`define RPC_STATUS_OFS  8'h28
`define RPC_GEN_OFS     8'h2c
`define RPC_HOLDER_OFS  8'h30
`define RPC_PFLBAL_OFS  8'h34
`define RPC_PFLBAH_OFS  8'h38
`define RPC_PFCNT_OFS   8'h3c
// Command launch kinds (CMD[1:0])
`define RPC_GO_PROUT    2'h1
`define RPC_GO_CDB      2'h2
`define RPC_GO_PWRLOSS  2'h3
// Service actions
`define RPC_SA_REGISTER 5'h00
`define RPC_SA_RESERVE  5'h01
`define RPC_SA_RELEASE  5'h02
`define RPC_SA_PREEMPT  5'h05
// Opcodes and status
`define RPC_OP_PF10     8'h34
`define RPC_OP_PF16     8'h90
`define RPC_ST_GOOD     8'h00
`define RPC_ST_CHECK    8'h02
`define RPC_ST_CONFLICT 8'h18
`define RPC_SK_NONE     4'h0
`define RPC_SK_ILLEGAL  4'h5
`define RPC_ASC_NONE    8'h00
`define RPC_ASC_BADOP   8'h20
`define RPC_ASC_BADFLD  8'h24
`endif

// file: core/rpc_pkg.sv
// Types shared by the reservation/prefetch block
`default_nettype none
package rpc_pkg;
  typedef enum logic [1:0] {
    RPC_IDLE  = 2'b00,
    RPC_STAGE = 2'b01,
    RPC_WAIT  = 2'b10
  } rpc_state_t;

  typedef struct packed {
    rpc_state_t        st;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
    logic [2:0]        init;
    logic [15:0]       action;
    logic [63:0]       rkey;
    logic [63:0]       akey;
    logic [3:0][31:0]  cdb;
    logic [7:0]        status;
    logic [3:0]        sense;
    logic [7:0]        asc;
    logic              done;
    logic [31:0]       gen;
    logic [7:0][63:0]  keys;
    logic [7:0]        regd;
    logic              held;
    logic [1:0]        holder;
    logic [7:0]        scope_type;
    logic              persist;
    logic [63:0]       lba;
    logic [31:0]       left;
    logic              to_end;
    logic [31:0]       count;
    logic              stage_req;
  } rpc_state_s_t;
endpackage : rpc_pkg
`default_nettype wire

// file: core/rpc_top.sv
// Reservation command handling and prefetch decode/staging engine
`include "rpc_regs.svh"
`default_nettype none
// What this block does
// - Service actions 0 register, 1 reserve, 2 release, 5 preempt are recognised.
// - Register ignores scope and type fields.
// - Reserve, release and preempt use the supplied scope and type.
// - Every service action checks supplied key before any effect.
// - Key held by another initiator ends with reservation conflict.
// - Register stores the action key as the requester's key.
// - Preempt takes the reservation holding the action key.
// - Other actions ignore the action key field.
// - Persist bit honoured only on register.
// - Power loss with persist 0 clears keys and reservation; with 1 keeps.
// - Generation increments on good register or preempt; zero after power loss.
// - Ten-byte prefetch: opcode 34h, address 2-5, length 7-8, immediate bit1.
// - Sixteen-byte prefetch: opcode 90h, address 2-9, length 10-13, group zero.
// - Prefetch only stages blocks into cache; no data to initiator.
// - Length counts contiguous blocks from the given address.
// - Zero length stages until segment full or last medium block.
// - Status held back until prefetch fully completes.
// - Immediate set gives check condition, illegal request, invalid field.
// - All-ports bit registers on every port, else receiving port only.
module rpc_top
  import rpc_pkg::*;
(
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Cache staging port
  output logic             stage_req,
  output logic [63:0]      stage_lba,
  input  wire logic        stage_ack,
  input  wire logic        seg_full,
  input  wire logic [63:0] last_lba
);
  import rpc_pkg::*;

  rpc_state_s_t r_reg;
  rpc_state_s_t r_next;

  // ****************************************
  // CDB field extraction
  // ****************************************
  logic [15:0][7:0] cb;
  logic [2:0]       ent;
  logic [4:0]       sa;
  logic             wr_hit;
  logic             rd_hit;
  logic             go;
  logic             mapped;
  logic [63:0]      own_key;
  logic             own_reg;
  logic             foreign;
  logic             eop;

  assign cb      = r_reg.cdb;
  assign ent     = pwdata[10:8]; // CMD word being written
  assign sa      = r_reg.action[4:0];
  assign own_key = r_reg.keys[ent];
  assign own_reg = r_reg.regd[ent];
  assign wr_hit  = psel && penable && pwrite && !r_reg.pready;
  assign rd_hit  = psel && penable && !pwrite && !r_reg.pready;

  // ****************************************
  // Command and action word fields
  // ****************************************
  logic [1:0]  cmd_kind;
  logic [1:0]  cmd_init;
  logic        cmd_port;
  logic [7:0]  act_scope;
  logic        act_persist;
  logic        act_all_ports;
  logic        key_ok;
  logic        cdb_pf10;
  logic        cdb_pf16;
  logic        cdb_immed;
  logic        cdb_group_bad;
  logic [63:0] cdb_lba;
  logic [31:0] cdb_len;
  logic [7:0]  reg_mask;
  logic [7:0]  victim;

  // Live write data: only meaningful in the cycle a CMD write is taken
  assign cmd_kind      = pwdata[1:0];
  assign cmd_init      = pwdata[10:9];
  assign cmd_port      = pwdata[8];
  assign act_scope     = r_reg.action[7:0];
  assign act_persist   = r_reg.action[8];
  assign act_all_ports = r_reg.action[9];
  assign cdb_pf10      = cb[0] == `RPC_OP_PF10;
  assign cdb_pf16      = cb[0] == `RPC_OP_PF16;
  assign cdb_immed     = cb[1][1];
  assign cdb_group_bad = cdb_pf16 && cb[14][4:0] != 5'h00;

  // A newcomer may only register, and only with a zero key
  assign key_ok = own_reg ? r_reg.rkey == own_key
                          : (sa == `RPC_SA_REGISTER && r_reg.rkey == 64'h0);

  // Wide form straight from its bytes; short form zero-extended
  always_comb begin
    if (cdb_pf16) begin
      cdb_lba = {cb[2], cb[3], cb[4], cb[5], cb[6], cb[7], cb[8], cb[9]};
      cdb_len = {cb[10], cb[11], cb[12], cb[13]};
    end else begin
      cdb_lba = {32'h0, cb[2], cb[3], cb[4], cb[5]};
      cdb_len = {16'h0, cb[7], cb[8]};
    end
  end

  // Entry i belongs to initiator i[2:1] on port i[0]
  always_comb begin
    reg_mask = 8'h00;
    victim   = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (i[2:1] == cmd_init && (act_all_ports || i[0] == cmd_port)) begin
        reg_mask[i] = 1'b1;
      end
      if (r_reg.regd[i] && r_reg.keys[i] == r_reg.akey && i[2:1] != cmd_init) begin
        victim[i] = 1'b1;
      end
    end
  end

  always_comb begin
    mapped = 1'b1;
    unique case (paddr)
      `RPC_CMD_OFS, `RPC_ACTION_OFS, `RPC_RKEYL_OFS, `RPC_RKEYH_OFS,
      `RPC_AKEYL_OFS, `RPC_AKEYH_OFS, `RPC_CDB0_OFS, `RPC_CDB1_OFS,
      `RPC_CDB2_OFS, `RPC_CDB3_OFS, `RPC_STATUS_OFS, `RPC_GEN_OFS,
      `RPC_HOLDER_OFS, `RPC_PFLBAL_OFS, `RPC_PFLBAH_OFS,
      `RPC_PFCNT_OFS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Key presented matches a registration of some other initiator
  always_comb begin
    foreign = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (r_reg.regd[i] && r_reg.keys[i] == r_reg.rkey
          && i[2:1] != ent[2:1]) begin
        foreign = 1'b1;
      end
    end
  end

  // End of a staging run
  assign eop = r_reg.to_end ? (seg_full || r_reg.lba == last_lba)
                            : (r_reg.left == 32'h0000_0001);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    r_next           = r_reg;
    r_next.pready    = 1'b0;
    r_next.pslverr   = 1'b0;
    r_next.stage_req = 1'b0;
    go               = 1'b0;

    // APB access: answer on the second access cycle
    if (psel && penable && !r_reg.pready) begin
      r_next.pready  = 1'b1;
      r_next.pslverr = !mapped;
      r_next.prdata  = 32'h0000_0000;
    end

    if (rd_hit) begin
      unique case (paddr)
        `RPC_CMD_OFS:    r_next.prdata = {29'h0, r_reg.init};
        `RPC_ACTION_OFS: r_next.prdata = {16'h0, r_reg.action};
        `RPC_RKEYL_OFS:  r_next.prdata = r_reg.rkey[31:0];
        `RPC_RKEYH_OFS:  r_next.prdata = r_reg.rkey[63:32];
        `RPC_AKEYL_OFS:  r_next.prdata = r_reg.akey[31:0];
        `RPC_AKEYH_OFS:  r_next.prdata = r_reg.akey[63:32];
        `RPC_CDB0_OFS:   r_next.prdata = r_reg.cdb[0];
        `RPC_CDB1_OFS:   r_next.prdata = r_reg.cdb[1];
        `RPC_CDB2_OFS:   r_next.prdata = r_reg.cdb[2];
        `RPC_CDB3_OFS:   r_next.prdata = r_reg.cdb[3];
        `RPC_STATUS_OFS: r_next.prdata = {6'h0, r_reg.done,
                                          r_reg.st != RPC_IDLE,
                                          r_reg.asc, 4'h0,
                                          r_reg.sense, r_reg.status};
        `RPC_GEN_OFS:    r_next.prdata = r_reg.gen;
        `RPC_HOLDER_OFS: r_next.prdata = {r_reg.regd, 7'h0,
                                          r_reg.persist,
                                          r_reg.scope_type, 4'h0,
                                          r_reg.held, 1'b0,
                                          r_reg.holder};
        `RPC_PFLBAL_OFS: r_next.prdata = r_reg.lba[31:0];
        `RPC_PFLBAH_OFS: r_next.prdata = r_reg.lba[63:32];
        `RPC_PFCNT_OFS:  r_next.prdata = r_reg.count;
        default:         r_next.prdata = 32'h0000_0000;
      endcase
    end

    // Writes are refused while a prefetch runs
    if (wr_hit && mapped && r_reg.st != RPC_IDLE) begin
      r_next.pslverr = 1'b1;
    end else if (wr_hit) begin
      unique case (paddr)
        `RPC_CMD_OFS: begin
          r_next.init = pwdata[10:8];
          go          = 1'b1;
        end
        `RPC_ACTION_OFS: r_next.action    = pwdata[15:0];
        `RPC_RKEYL_OFS:  r_next.rkey[31:0]  = pwdata;
        `RPC_RKEYH_OFS:  r_next.rkey[63:32] = pwdata;
        `RPC_AKEYL_OFS:  r_next.akey[31:0]  = pwdata;
        `RPC_AKEYH_OFS:  r_next.akey[63:32] = pwdata;
        `RPC_CDB0_OFS:   r_next.cdb[0] = pwdata;
        `RPC_CDB1_OFS:   r_next.cdb[1] = pwdata;
        `RPC_CDB2_OFS:   r_next.cdb[2] = pwdata;
        `RPC_CDB3_OFS:   r_next.cdb[3] = pwdata;
        default: ;
      endcase
    end

    // ****************************************
    // Command launch
    // ****************************************
    if (go) begin
      r_next.done   = 1'b1;
      r_next.status = `RPC_ST_GOOD;
      r_next.sense  = `RPC_SK_NONE;
      r_next.asc    = `RPC_ASC_NONE;
      unique case (cmd_kind)
        `RPC_GO_PROUT: begin
          // Action and keys come from the registers, the requester from
          // the CMD word itself, so the check names the initiator asking.
          if (foreign) begin
            r_next.status = `RPC_ST_CONFLICT;
          end else if (!key_ok) begin
            r_next.status = `RPC_ST_CONFLICT;
          end else begin
            unique case (sa)
              `RPC_SA_REGISTER: begin
                // Scope/type and extent untouched here
                for (int i = 0; i < 8; i++) begin
                  if (reg_mask[i]) begin
                    r_next.keys[i] = r_reg.akey;
                    r_next.regd[i] = r_reg.akey != 64'h0;
                  end
                end
                r_next.persist = act_persist;
                r_next.gen     = r_reg.gen + 32'h1;
              end
              `RPC_SA_RESERVE: begin
                if (r_reg.held && r_reg.holder != cmd_init) begin
                  r_next.status = `RPC_ST_CONFLICT;
                end else begin
                  r_next.held       = 1'b1;
                  r_next.holder     = cmd_init;
                  r_next.scope_type = act_scope;
                end
              end
              `RPC_SA_RELEASE: begin
                // Action key not looked at, . Low bits of the stored
                // byte hold the reserving action code, so only [7:5] compare.
                if (r_reg.held && r_reg.holder == cmd_init
                    && r_reg.scope_type[7:5] == act_scope[7:5]) begin
                  r_next.held = 1'b0;
                end
              end
              `RPC_SA_PREEMPT: begin
                for (int i = 0; i < 8; i++) begin
                  if (victim[i]) begin
                    r_next.regd[i] = 1'b0;
                    if (r_reg.held && r_reg.holder == i[2:1]) begin
                      r_next.holder     = cmd_init;
                      r_next.scope_type = act_scope;
                    end
                  end
                end
                r_next.gen = r_reg.gen + 32'h1;
              end
              default: begin
                r_next.status = `RPC_ST_CHECK;
                r_next.sense  = `RPC_SK_ILLEGAL;
                r_next.asc    = `RPC_ASC_BADFLD;
              end
            endcase
          end
        end
        `RPC_GO_CDB: begin
          r_next.count = 32'h0;
          if (!cdb_pf10 && !cdb_pf16) begin
            r_next.status = `RPC_ST_CHECK;
            r_next.sense  = `RPC_SK_ILLEGAL;
            r_next.asc    = `RPC_ASC_BADOP;
          end else if (cdb_immed || cdb_group_bad) begin
            r_next.status = `RPC_ST_CHECK;
            r_next.sense  = `RPC_SK_ILLEGAL;
            r_next.asc    = `RPC_ASC_BADFLD;
          end else begin
            r_next.lba    = cdb_lba;
            r_next.left   = cdb_len;
            r_next.to_end = cdb_len == 32'h0;
            r_next.done   = 1'b0;
            r_next.st     = RPC_STAGE;
          end
        end
        `RPC_GO_PWRLOSS: begin
          if (!r_reg.persist) begin
            r_next.keys = '0;
            r_next.regd = '0;
            r_next.held = 1'b0;
          end
          r_next.gen = 32'h0;
        end
        default: r_next.done = r_reg.done;
      endcase
    end

    // ****************************************
    // Staging into cache; no data path to host
    // ****************************************
    unique case (r_reg.st)
      RPC_IDLE: ;
      RPC_STAGE: begin
        if (r_reg.to_end && seg_full) begin
          r_next.st   = RPC_IDLE;
          r_next.done = 1'b1;
        end else begin
          r_next.stage_req = 1'b1;
          r_next.st        = RPC_WAIT;
        end
      end
      RPC_WAIT: begin
        if (stage_ack) begin
          r_next.count = r_reg.count + 32'h1;
          if (eop) begin
            r_next.st   = RPC_IDLE;
            r_next.done = 1'b1;
          end else begin
            r_next.lba  = r_reg.lba + 64'h1;
            r_next.left = r_reg.left - 32'h1;
            r_next.st   = RPC_STAGE;
          end
        end
      end
      default: r_next.st = RPC_IDLE;
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg      <= '0;
      r_reg.st   <= RPC_IDLE;
      r_reg.done <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign pready    = r_reg.pready;
  assign pslverr   = r_reg.pslverr;
  assign prdata    = r_reg.prdata;
  assign stage_req = r_reg.stage_req;
  assign stage_lba = r_reg.lba;
endmodule : rpc_top
`default_nettype wire

// file: sim/rpc_chk.sv
// Port-level assertions for the reservation/prefetch block
`default_nettype none
module rpc_chk (
  // APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  // Staging
  input wire logic        stage_req,
  input wire logic [63:0] stage_lba,
  input wire logic        stage_ack,
  input wire logic        seg_full,
  input wire logic [63:0] last_lba
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy_once; pready |=> !pready; endproperty
  a_rdy_once: assert property (p_rdy_once) else $error("pready held too long");
  property p_rdy_ans; psel && penable && !pready |=> pready; endproperty
  a_rdy_ans: assert property (p_rdy_ans) else $error("access not answered");
  property p_rdy_cause; pready |-> $past(psel && penable); endproperty
  a_rdy_cause: assert property (p_rdy_cause) else $error("pready without access");
  property p_err_qual; pslverr |-> pready; endproperty
  a_err_qual: assert property (p_err_qual) else $error("pslverr outside answer");
  property p_unmapped; psel && penable && !pready && paddr > 8'h3c |=> pslverr && prdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
  property p_wr_quiet; pready && $past(pwrite) |-> prdata == 32'h0; endproperty
  a_wr_quiet: assert property (p_wr_quiet) else $error("read data on a write");
  property p_stage_pulse; stage_req |=> !stage_req; endproperty
  a_stage_pulse: assert property (p_stage_pulse) else $error("stage request not a pulse");
  property p_lba_hold; stage_req |=> $stable(stage_lba); endproperty
  a_lba_hold: assert property (p_lba_hold) else $error("stage address moved early");
endmodule : rpc_chk
bind rpc_top rpc_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .prdata, .stage_req, .stage_lba, .stage_ack, .seg_full, .last_lba);
`default_nettype wire

// file: sim/rpc_cache_model.sv
// Cache segment model answering block staging requests
`default_nettype none
module rpc_cache_model #(
  parameter logic [63:0] LAST = 64'h0000_ffff
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Staging
  input  wire logic        stage_req,
  input  wire logic [63:0] stage_lba,
  output logic             stage_ack,
  output logic             seg_full,
  output logic [63:0]      last_lba,
  // Bench knobs
  input  wire logic [3:0]  delay,
  input  wire logic [7:0]  cap,
  input  wire logic        clr
);
  logic [3:0] cnt;
  logic       busy;
  logic [7:0] staged;
  assign last_lba = LAST;
  // Full flag rises with the ack that fills the segment
  assign seg_full = (staged >= cap);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
      busy <= 1'b0;
      staged <= 8'h00;
      stage_ack <= 1'b0;
    end else begin
      stage_ack <= 1'b0;
      if (clr) begin
        staged <= 8'h00;
      end
      if (stage_req) begin
        busy <= 1'b1;
        cnt <= delay;
      end else if (busy && cnt == 4'h0) begin
        busy <= 1'b0;
        stage_ack <= 1'b1;
        staged <= staged + 8'h01;
      end else if (busy) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule : rpc_cache_model
`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for the reservation/prefetch block
`include "rpc_regs.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] DONE = 32'h0200_0000;
  localparam logic [31:0] BAD  = 32'h0224_0502;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, clr = 0, e;
  logic [7:0]  paddr = 8'h00, cap = 8'hff;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, stage_req, stage_ack, seg_full;
  logic [63:0] stage_lba, last_lba;
  logic [3:0]  delay = 4'h0;
  logic [63:0] lbas[$];
  int          n_errors = 0, total_checks = 0;
  always #20 pclk = ~pclk;
  always @(posedge pclk) begin
    if (stage_req === 1'b1) begin
      lbas.push_back(stage_lba);
    end
  end
  rpc_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
    .prdata, .stage_req, .stage_lba, .stage_ack, .seg_full, .last_lba);
  rpc_cache_model u_cache (.pclk, .presetn, .stage_req, .stage_lba, .stage_ack, .seg_full,
    .last_lba, .delay, .cap, .clr);
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Request held until pready is sampled, then one idle edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) begin
      n_errors++;
      tally_and_finish();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic pr(input logic [31:0] cmd, act, rk, ak);
    apb(1'b1, `RPC_ACTION_OFS, act);
    apb(1'b1, `RPC_RKEYL_OFS, rk);
    apb(1'b1, `RPC_AKEYL_OFS, ak);
    apb(1'b1, `RPC_CMD_OFS, cmd);
    apb(1'b0, `RPC_STATUS_OFS, 32'h0);
  endtask : pr
  task automatic pf(input logic [31:0] w0, w1, w2, w3);
    lbas.delete();
    apb(1'b1, `RPC_CDB0_OFS, w0);
    apb(1'b1, `RPC_CDB1_OFS, w1);
    apb(1'b1, `RPC_CDB2_OFS, w2);
    apb(1'b1, `RPC_CDB3_OFS, w3);
    apb(1'b1, `RPC_CMD_OFS, 32'h2);
  endtask : pf
  task automatic pf_wait();
    int i;
    i = 0;
    do begin
      apb(1'b0, `RPC_STATUS_OFS, 32'h0);
      i++;
    end while (!(q[25] === 1'b1 && q[24] === 1'b0) && i < 100);
    chk(64'(i < 100), 64'h1);
    if (i >= 100) begin
      tally_and_finish();
    end
  endtask : pf_wait
  task automatic t_pr_flow();
    apb(1'b0, `RPC_STATUS_OFS, 32'h0);
    chk(q, DONE);
    pr(32'h1, 32'h160, 32'h0, 32'ha);
    chk(q, DONE);
    pr(32'h1, 32'h061, 32'ha, 32'h77);
    chk(q, DONE);
    apb(1'b0, `RPC_HOLDER_OFS, 32'h0);
    chk({q[31:24], q[16], q[15:0]}, 64'h0_3_6108);
    pr(32'h201, 32'h061, 32'ha, 32'h0);
    chk(q, 32'h0200_0018);
    pr(32'h1, 32'h061, 32'h5, 32'h0);
    chk(q, 32'h0200_0018);
    pr(32'h1, 32'h063, 32'ha, 32'h0);
    chk(q, BAD);
    apb(1'b0, `RPC_GEN_OFS, 32'h0);
    chk(q, 32'h1);
    pr(32'h3, 32'h0, 32'h0, 32'h0);
    apb(1'b0, `RPC_HOLDER_OFS, 32'h0);
    chk({q[31:24], q[3]}, 9'h003);
    apb(1'b0, `RPC_GEN_OFS, 32'h0);
    chk(q, 32'h0);
  endtask : t_pr_flow
  task automatic t_preempt();
    pr(32'h201, 32'h200, 32'h0, 32'hb);
    apb(1'b0, `RPC_HOLDER_OFS, 32'h0);
    chk(q[31:24], 8'h0d);
    pr(32'h201, 32'h065, 32'hb, 32'ha);
    chk(q, DONE);
    apb(1'b0, `RPC_HOLDER_OFS, 32'h0);
    chk({q[31:24], q[3:0]}, 12'h0c9);
    apb(1'b0, `RPC_GEN_OFS, 32'h0);
    chk(q, 32'h2);
    pr(32'h201, 32'h042, 32'hb, 32'h55);
    apb(1'b0, `RPC_HOLDER_OFS, 32'h0);
    chk({q[31:24], q[3:0]}, 12'h0c9);
    pr(32'h201, 32'h062, 32'hb, 32'h55);
    chk(q, DONE);
    apb(1'b0, `RPC_HOLDER_OFS, 32'h0);
    chk({q[31:24], q[3:0]}, 12'h0c1);
    pr(32'h3, 32'h0, 32'h0, 32'h0);
    apb(1'b0, `RPC_HOLDER_OFS, 32'h0);
    chk({q[31:24], q[3]}, 9'h000);
  endtask : t_preempt
  task automatic t_pf10();
    delay <= 4'h3;
    pf(32'h34, 32'h10, 32'h2, 32'h0);
    apb(1'b1, `RPC_CMD_OFS, 32'h2);
    chk(e, 1'b1);
    apb(1'b0, `RPC_STATUS_OFS, 32'h0);
    chk(q[25:24], 2'b01);
    pf_wait();
    chk(q, DONE);
    chk({lbas[0], lbas[1], 64'(lbas.size())}, {64'h1000, 64'h1001, 64'h2});
    apb(1'b0, `RPC_PFCNT_OFS, 32'h0);
    chk(q, 32'h2);
  endtask : t_pf10
  task automatic t_pf16();
    cap <= 8'h03;
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    pf(32'h90, 32'h0, 32'h2000, 32'h0);
    pf_wait();
    chk({lbas[0], 64'(lbas.size())}, {64'h20, 64'h3});
    apb(1'b0, `RPC_PFCNT_OFS, 32'h0);
    chk(q, 32'h3);
    cap <= 8'hff;
  endtask : t_pf16
  task automatic t_bad();
    pf(32'h234, 32'h10, 32'h2, 32'h0);
    pf_wait();
    chk({q, 32'(lbas.size())}, {BAD, 32'h0});
    pf(32'h90, 32'h0, 32'h2000, 32'h0001_0000);
    pf_wait();
    chk(q, BAD);
    apb(1'b0, 8'h40, 32'h0);
    chk({e, q}, {1'b1, 32'h0});
  endtask : t_bad
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_pr_flow();
    t_preempt();
    t_pf10();
    t_pf16();
    t_bad();
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
